// ===== apc_pkg.sv
package apc_pkg;
  // ----------------------------------------------------------------------
  // Register word indexes; the bus byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [7:0] APC_PORT_CONFIG_OFF = 8'h9f;
  localparam logic [7:0] APC_PRIMARY_CTRL_OFF = 8'h1f;
  localparam logic [7:0] APC_RESULT_HIGH_OFF = 8'h1e;
  localparam logic [7:0] APC_RESULT_LOW_OFF = 8'h9e;
  localparam logic [7:0] APC_IRQ_STATUS_OFF = 8'ha0;
  localparam logic [7:0] APC_IRQ_MASK_OFF = 8'ha4;
  localparam logic [7:0] APC_SAMPLE_OFF = 8'ha8;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int APC_JUSTIFY_BIT = 7;
  localparam int APC_CLK_HIGH_BIT = 6;
  localparam int APC_CLK_LOW_MSB = 7;
  localparam int APC_CLK_LOW_LSB = 6;
  localparam int APC_CHAN_MSB = 5;
  localparam int APC_CHAN_LSB = 3;
  localparam int APC_GO_BIT = 2;
  localparam int APC_POWER_BIT = 0;
  localparam int APC_DONE_BIT = 0;
  // ----------------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] APC_PORT_CONFIG_RST = 8'h00;
  localparam logic [7:0] APC_PORT_CONFIG_WMASK = 8'hcf;
  localparam logic [7:0] APC_PRIMARY_CTRL_RST = 8'h00;
  localparam logic [7:0] APC_PRIMARY_CTRL_WMASK = 8'hfd;
  localparam logic [7:0] APC_RESULT_RST = 8'h00;
  localparam logic [7:0] APC_ALL_ANALOG = 8'hff;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int APC_CLK_MHZ = 50;
  localparam int APC_CONV_PERIODS = 12;
  localparam int APC_RC_TAD_NS = 4000;
  localparam int APC_RC_TAD_CYC = (APC_RC_TAD_NS * APC_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    APC_IDLE = 3'b001,
    APC_CONV = 3'b010,
    APC_LOAD = 3'b100
  } apc_state_t;
endpackage

// ===== apc_tad_gen.sv
`timescale 1ns/1ps
module apc_tad_gen
  import apc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic clk_high,
  input wire logic [1:0] clk_low,
  output logic tad_tick
);
  logic [7:0] div_sel;
  logic [7:0] cnt_r;

  // Divide ratio from the three select bits; 11 picks the RC substitute
  always_comb begin
    unique case (clk_low)
      2'b00: div_sel = clk_high ? 8'd4 : 8'd2;
      2'b01: div_sel = clk_high ? 8'd16 : 8'd8;
      2'b10: div_sel = clk_high ? 8'd64 : 8'd32;
      2'b11: div_sel = 8'(APC_RC_TAD_CYC);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || tad_tick) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign tad_tick = run && (cnt_r == div_sel - 8'h01);
endmodule

// ===== apc_port_decode.sv
`timescale 1ns/1ps
module apc_port_decode
  import apc_pkg::*;
(
  input wire logic [3:0] port_config_field,
  output logic [7:0] analog_input_pin
);
  always_comb begin
    unique case (port_config_field)
      4'h0: analog_input_pin = 8'hff;
      4'h1: analog_input_pin = 8'hf7;
      4'h2: analog_input_pin = 8'h1f;
      4'h3: analog_input_pin = 8'h17;
      4'h4: analog_input_pin = 8'h0b;
      4'h5: analog_input_pin = 8'h03;
      4'h6, 4'h7: analog_input_pin = 8'h00;
      4'h8: analog_input_pin = 8'hf3;
      4'h9: analog_input_pin = 8'h3f;
      4'ha: analog_input_pin = 8'h37;
      4'hb: analog_input_pin = 8'h33;
      4'hc: analog_input_pin = 8'h13;
      4'hd: analog_input_pin = 8'h03;
      4'he: analog_input_pin = 8'h01;
      4'hf: analog_input_pin = 8'h01;
    endcase
  end
endmodule

// ===== apc_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module apc_top
  import apc_pkg::*;
#(
  parameter int RESULT_BITS = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [RESULT_BITS-1:0] sample_data,
  output logic [7:0] analog_input_pin,
  output logic [2:0] channel_select,
  output logic converter_power_on,
  output logic sample_hold,
  output logic conv_irq
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] port_cfg_r;
  logic [7:0] ctrl_r;
  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic done_flag_r;
  logic irq_en_r;
  apc_state_t state_r;
  logic [3:0] tad_cnt_r;
  logic [RESULT_BITS-1:0] sample_r;
  logic tad_tick;
  logic conv_done;

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  logic [7:0] aw_addr_r;
  logic aw_held_r;
  logic [7:0] w_data_r;
  logic w_be_r;
  logic w_held_r;
  logic wr_fire;
  logic [7:0] rd_addr;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r;
  assign s_axi_bresp = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr[9:2];
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_be_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_be_r <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // Unmapped writes are accepted with OKAY and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr_fire && w_be_r && (aw_addr_r == off);
  endfunction

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_cfg_r <= APC_PORT_CONFIG_RST;
    end else if (wr_hit(APC_PORT_CONFIG_OFF)) begin
      port_cfg_r <= w_data_r & APC_PORT_CONFIG_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_r <= 1'b0;
    end else if (wr_hit(APC_IRQ_MASK_OFF)) begin
      irq_en_r <= w_data_r[APC_DONE_BIT];
    end
  end

  // Go bit: software may set or clear it; completion clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= APC_PRIMARY_CTRL_RST;
    end else begin
      if (wr_hit(APC_PRIMARY_CTRL_OFF)) begin
        ctrl_r <= w_data_r & APC_PRIMARY_CTRL_WMASK;
        // Go set together with power-on is ignored until already powered
        if (!ctrl_r[APC_POWER_BIT] || !w_data_r[APC_POWER_BIT]) begin
          ctrl_r[APC_GO_BIT] <= 1'b0;
        end
      end
      // Completion clears go even over a same-cycle software write
      if (conv_done) begin
        ctrl_r[APC_GO_BIT] <= 1'b0;
      end
    end
  end

  assign converter_power_on = ctrl_r[APC_POWER_BIT];
  assign channel_select = ctrl_r[APC_CHAN_MSB:APC_CHAN_LSB];
  logic [7:0] port_pins;
  assign analog_input_pin = aresetn ? port_pins : APC_ALL_ANALOG;

  apc_port_decode u_decode (
    .port_config_field(port_cfg_r[3:0]),
    .analog_input_pin(port_pins)
  );

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  logic go_live;
  assign go_live = ctrl_r[APC_GO_BIT] && ctrl_r[APC_POWER_BIT];

  apc_tad_gen u_tad (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_r == APC_CONV),
    .clk_high(port_cfg_r[APC_CLK_HIGH_BIT]),
    .clk_low(ctrl_r[APC_CLK_LOW_MSB:APC_CLK_LOW_LSB]),
    .tad_tick(tad_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= APC_IDLE;
      tad_cnt_r <= 4'h0;
      sample_r <= '0;
    end else begin
      unique case (state_r)
        APC_IDLE: begin
          tad_cnt_r <= 4'h0;
          if (go_live) begin
            state_r <= APC_CONV;
            sample_r <= sample_data;
          end
        end
        APC_CONV: begin
          if (!go_live) begin
            state_r <= APC_IDLE;
          end else if (tad_tick) begin
            if (tad_cnt_r == 4'(APC_CONV_PERIODS - 1)) begin
              state_r <= APC_LOAD;
            end
            tad_cnt_r <= tad_cnt_r + 4'h1;
          end
        end
        APC_LOAD: begin
          state_r <= APC_IDLE;
        end
        default: begin
          state_r <= APC_IDLE;
        end
      endcase
    end
  end

  assign conv_done = (state_r == APC_LOAD);
  assign sample_hold = (state_r == APC_CONV);

  // Result pair: loaded only at completion, or written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_hi_r <= APC_RESULT_RST;
      res_lo_r <= APC_RESULT_RST;
    end else if (conv_done) begin
      if (port_cfg_r[APC_JUSTIFY_BIT]) begin
        res_hi_r <= {6'h00, sample_r[9:8]};
        res_lo_r <= sample_r[7:0];
      end else begin
        res_hi_r <= sample_r[9:2];
        res_lo_r <= {sample_r[1:0], 6'h00};
      end
    end else begin
      if (wr_hit(APC_RESULT_HIGH_OFF)) begin
        res_hi_r <= w_data_r;
      end
      if (wr_hit(APC_RESULT_LOW_OFF)) begin
        res_lo_r <= w_data_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Done flag and interrupt
  // ----------------------------------------------------------------------
  // Set wins over a same-cycle write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag_r <= 1'b0;
    end else if (conv_done) begin
      done_flag_r <= 1'b1;
    end else if (wr_hit(APC_IRQ_STATUS_OFF) && w_data_r[APC_DONE_BIT]) begin
      done_flag_r <= 1'b0;
    end
  end

  assign conv_irq = done_flag_r && irq_en_r;

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr = s_axi_araddr[9:2];
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (rd_addr)
        APC_PORT_CONFIG_OFF: s_axi_rdata <= {24'h0, port_cfg_r};
        APC_PRIMARY_CTRL_OFF: s_axi_rdata <= {24'h0, ctrl_r};
        APC_RESULT_HIGH_OFF: s_axi_rdata <= {24'h0, res_hi_r};
        APC_RESULT_LOW_OFF: s_axi_rdata <= {24'h0, res_lo_r};
        APC_IRQ_STATUS_OFF: s_axi_rdata <= {31'h0, done_flag_r};
        APC_IRQ_MASK_OFF: s_axi_rdata <= {31'h0, irq_en_r};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_justify_right;
    @(posedge aclk) disable iff (!aresetn)
      $past(conv_done) && $past(port_cfg_r[APC_JUSTIFY_BIT])
        |-> res_hi_r[7:2] == 6'h00;
  endproperty
  a_justify_right: assert property (p_justify_right)
    else $error("right justify high bits not zero");

  property p_justify_left;
    @(posedge aclk) disable iff (!aresetn)
      $past(conv_done) && !$past(port_cfg_r[APC_JUSTIFY_BIT])
        |-> res_lo_r[5:0] == 6'h00;
  endproperty
  a_justify_left: assert property (p_justify_left)
    else $error("left justify low bits not zero");

  property p_unimpl_zero;
    @(posedge aclk) disable iff (!aresetn) port_cfg_r[5:4] == 2'b00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("port config bits 5 4 not zero");

  property p_done_sets;
    @(posedge aclk) disable iff (!aresetn)
      conv_done |=> done_flag_r && !ctrl_r[APC_GO_BIT];
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("completion did not set done and clear go");

  property p_abort_keeps;
    @(posedge aclk) disable iff (!aresetn)
      state_r == APC_CONV && !go_live
        |=> $stable(res_hi_r) && $stable(res_lo_r) && !conv_done;
  endproperty
  a_abort_keeps: assert property (p_abort_keeps)
    else $error("abort changed result");

  property p_min_time;
    @(posedge aclk) disable iff (!aresetn)
      $rose(sample_hold) |-> !conv_done [*8];
  endproperty
  a_min_time: assert property (p_min_time)
    else $error("conversion shorter than minimum");

  property p_conv_periods;
    @(posedge aclk) disable iff (!aresetn)
      conv_done |-> tad_cnt_r == 4'(APC_CONV_PERIODS);
  endproperty
  a_conv_periods: assert property (p_conv_periods)
    else $error("conversion ended after wrong period count");

  property p_power_gate;
    @(posedge aclk) disable iff (!aresetn)
      !converter_power_on |=> !sample_hold;
  endproperty
  a_power_gate: assert property (p_power_gate)
    else $error("converting while powered down");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      conv_done && irq_en_r && !wr_fire |=> conv_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt mismatch");

  property p_done_sticky;
    @(posedge aclk) disable iff (!aresetn)
      done_flag_r && !wr_fire |=> done_flag_r;
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("done flag cleared without a write");
endmodule

// ===== apc_far_model.sv
`timescale 1ns/1ps
module apc_far_model (
  input wire logic [2:0] channel_select,
  input wire logic converter_power_on,
  input wire logic [7:0] analog_input_pin,
  output logic [9:0] sample_data
);
  // ----------------------------------------------------------------
  // Analog source levels
  // ----------------------------------------------------------------
  logic [9:0] level;
  assign level = 10'h2a5 ^ {channel_select, channel_select,
                            channel_select, 1'b0};
  // A digital or unpowered pin gives no valid level, so show a wrong one
  always_comb begin
    if (converter_power_on && analog_input_pin[channel_select]) begin
      sample_data = level;
    end else begin
      sample_data = ~level;
    end
  end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import apc_pkg::*;
  localparam int ACQ = 20;
  localparam logic [7:0] PIN_EXP [16] = '{8'hff, 8'hf7, 8'h1f, 8'h17,
    8'h0b, 8'h03, 8'h00, 8'h00, 8'hf3, 8'h3f, 8'h37, 8'h33, 8'h13,
    8'h03, 8'h01, 8'h01};
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic arvalid = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, hold, pwr;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v, last_hi, last_lo;
  logic [9:0] sdata;
  logic [7:0] pins;
  logic [2:0] chan;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int held = 0;

  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (hold === 1'b1) held <= held + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  apc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .sample_data(sdata), .analog_input_pin(pins),
    .channel_select(chan), .converter_power_on(pwr),
    .sample_hold(hold), .conv_irq(irq));
  apc_far_model far (.channel_select(chan), .converter_power_on(pwr),
    .analog_input_pin(pins), .sample_data(sdata));

  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Ready is sampled at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ha, hw, hb, ta, tw;
    logic [1:0] br;
    ha = 0;
    hw = 0;
    hb = 0;
    br = 2'b11;
    awaddr <= {22'h0, a, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    while (!(ha && hw)) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 0;
        ha = 1;
      end
      if (tw) begin
        wvalid <= 0;
        hw = 1;
      end
    end
    while (!hb) begin
      @(negedge aclk);
      hb = bvalid;
      br = bresp;
      @(posedge aclk);
    end
    chk({30'h0, br}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic t, hr;
    logic [1:0] rr;
    t = 0;
    hr = 0;
    rr = 2'b11;
    araddr <= {22'h0, a, 2'b00};
    arvalid <= 1;
    while (!t) begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 0;
    while (!hr) begin
      @(negedge aclk);
      hr = rvalid;
      d = rdata;
      rr = rresp;
      @(posedge aclk);
    end
    chk({30'h0, rr}, 32'h0);
  endtask

  task automatic chkr(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, {24'h0, e});
  endtask

  task automatic conv(input int i);
    logic [2:0] c;
    logic [9:0] s;
    logic [7:0] ctl, eh, el;
    logic jst, msk;
    int div, h0;
    c = i[2:0];
    jst = i[0];
    msk = i[1];
    div = (i[1:0] == 3) ? 200 : ((i[2] ? 4 : 2) << (2 * i[1:0]));
    s = 10'h2a5 ^ {c, c, c, 1'b0};
    ctl = {i[1:0], c, 3'b001};
    eh = jst ? {6'h0, s[9:8]} : s[9:2];
    el = jst ? s[7:0] : {s[1:0], 6'h0};
    wr(APC_PORT_CONFIG_OFF, {jst, i[2], 6'h00});
    wr(APC_PRIMARY_CTRL_OFF, ctl);
    wr(APC_IRQ_STATUS_OFF, 8'h01);
    wr(APC_IRQ_MASK_OFF, {7'h0, msk});
    repeat (ACQ) @(posedge aclk);
    h0 = held;
    wr(APC_PRIMARY_CTRL_OFF, ctl | 8'h04);
    rd(APC_PRIMARY_CTRL_OFF, v);
    chk(v & 32'h4, 32'h4);
    while (v[2] !== 1'b0) rd(APC_PRIMARY_CTRL_OFF, v);
    chk(v, {24'h0, ctl});
    chk({31'h0, held - h0 >= 12 * div}, 32'h1);
    chk({31'h0, held - h0 <= 13 * div + 4}, 32'h1);
    chkr(APC_IRQ_STATUS_OFF, 8'h01);
    chk({31'h0, irq}, {31'h0, msk});
    chkr(APC_RESULT_HIGH_OFF, eh);
    chkr(APC_RESULT_LOW_OFF, el);
    last_hi = {24'h0, eh};
    last_lo = {24'h0, el};
    wr(APC_IRQ_STATUS_OFF, 8'h01);
    chkr(APC_IRQ_STATUS_OFF, 8'h00);
    chk({31'h0, irq}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk({24'h0, pins}, 32'hff);
    chkr(APC_PORT_CONFIG_OFF, 8'h00);
    chkr(APC_PRIMARY_CTRL_OFF, 8'h00);
    for (int k = 0; k < 16; k++) begin
      wr(APC_PORT_CONFIG_OFF, {4'h3, k[3:0]});
      chk({24'h0, pins}, {24'h0, PIN_EXP[k]});
      chkr(APC_PORT_CONFIG_OFF, {4'h0, k[3:0]});
    end
    for (int i = 0; i < 8; i++) conv(i);
    wr(APC_PORT_CONFIG_OFF, 8'hc0);
    wr(APC_PRIMARY_CTRL_OFF, 8'ha9);
    wr(APC_RESULT_HIGH_OFF, 8'h5a);
    wr(APC_RESULT_LOW_OFF, 8'hc3);
    last_hi = 32'h5a;
    last_lo = 32'hc3;
    wr(APC_PRIMARY_CTRL_OFF, 8'had);
    repeat (100) @(posedge aclk);
    chk({31'h0, hold}, 32'h1);
    wr(APC_PRIMARY_CTRL_OFF, 8'ha9);
    repeat (4) @(posedge aclk);
    chk({31'h0, hold}, 32'h0);
    chkr(APC_IRQ_STATUS_OFF, 8'h00);
    rd(APC_RESULT_HIGH_OFF, v);
    chk(v, last_hi);
    rd(APC_RESULT_LOW_OFF, v);
    chk(v, last_lo);
    wr(APC_PRIMARY_CTRL_OFF, 8'h00);
    wr(APC_PRIMARY_CTRL_OFF, 8'h04);
    repeat (40) @(posedge aclk);
    chk({31'h0, hold}, 32'h0);
    chkr(APC_IRQ_STATUS_OFF, 8'h00);
    chkr(APC_PRIMARY_CTRL_OFF, 8'h00);
    chkr(8'h40, 8'h00);
    wr(8'h40, 8'hff);
    chkr(APC_PORT_CONFIG_OFF, 8'hc0);
    wr(APC_PORT_CONFIG_OFF, 8'h06);
    chk({24'h0, pins}, 32'h0);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    chk({24'h0, pins}, 32'hff);
    aresetn <= 1;
    @(posedge aclk);
    chkr(APC_PORT_CONFIG_OFF, 8'h00);
    finish_test();
  end
endmodule
